//--- pkg/led_bank_defs.svh
/*
  Constants of the LED bank serial control: bus addresses, internal register selectors,
  reset values, field positions and timing counts.
  Assumes a 20 MHz system clock on both ends; included by bare name.
*/
`ifndef LED_BANK_DEFS_SVH
`define LED_BANK_DEFS_SVH

// Slave addresses of the two variants.
`define LBC_ADDR_STD        7'h36
`define LBC_ADDR_ALT        7'h38

// Internal register selectors.
`define LBC_REG_GP          8'h10
`define LBC_REG_MAIN        8'hA0
`define LBC_REG_AUX         8'hB0
`define LBC_REG_IND         8'hC0

// Reset values of the internal registers.
`define LBC_RST_GP          8'h20
`define LBC_RST_MAIN        8'hE0
`define LBC_RST_AUX         8'hE0
`define LBC_RST_IND         8'hFC

// Bit positions in the general purpose register.
`define LBC_GP_MAIN_EN      0
`define LBC_GP_AUX_EN       1
`define LBC_GP_IND_EN       2
`define LBC_GP_PIN5_SENSE   3
`define LBC_GP_PIN3_EN      4

// Timing.
`define LBC_CLK_HZ          20000000
`define LBC_CLK_PERIOD_NS   50
`define LBC_PWM_FREQ_HZ     20000
`define LBC_PWM_SLOTS       16
`define LBC_PWM_PERIOD_CYC  (`LBC_CLK_HZ / `LBC_PWM_FREQ_HZ)
`define LBC_PWM_SLOT_CYC    (`LBC_PWM_PERIOD_CYC / `LBC_PWM_SLOTS)
`define LBC_SCL_PERIOD_NS   2500
`define LBC_SCL_QUARTER_CYC ((`LBC_SCL_PERIOD_NS + 4 * `LBC_CLK_PERIOD_NS - 1) / (4 * `LBC_CLK_PERIOD_NS))

`endif

//--- pkg/led_bank_pkg.sv
/*
  Types shared by both ends of the LED bank serial control.
  Assumes the constants of led_bank_defs.svh for all numeric values.
*/
package led_bank_pkg;

   // Analog current step of a sink group.
   typedef enum logic [1:0] {
      level_20,
      level_40,
      level_70,
      level_100
   } level_type;

   // Serial slave states.
   typedef enum logic [1:0] {
      slave_idle,
      slave_shift,
      slave_ack,
      slave_ignore
   } slave_state_type;

   // Serial master states.
   typedef enum logic [1:0] {
      host_idle,
      host_start,
      host_bit,
      host_stop
   } host_state_type;

endpackage

//--- pkg/led_bank_if.sv
/*
  Two-wire link between host and LED bank device, plus the active-low reset pin.
  Assumes open-drain data: each end drives only low; the wire level is resolved here.
*/
`timescale 1ns/1ps
interface led_bank_if;
   logic scl;
   logic reset_n;
   logic host_sda_out;
   logic host_sda_oe;
   logic dev_sda_out;
   logic dev_sda_oe;
   logic sda;

   // Wired-AND of both drivers with a pull-up when nobody drives.
   assign sda = (host_sda_oe ? host_sda_out : 1'b1) & (dev_sda_oe ? dev_sda_out : 1'b1);

   modport device (
      input  scl,
      input  reset_n,
      input  sda,
      output dev_sda_out,
      output dev_sda_oe
   );

   modport host (
      output scl,
      output reset_n,
      output host_sda_out,
      output host_sda_oe,
      input  sda
   );
endinterface

//--- hw/brightness_pwm.sv
/*
  Maps a 5-bit brightness code to an analog current step and a PWM duty over 16 slots.
  Assumes the caller supplies the running slot index of the internal PWM time base.
*/
`timescale 1ns/1ps
module brightness_pwm
   import led_bank_pkg::*;
(
   input  wire logic                   clk_sys,
   input  wire logic                   rst,
   input  wire logic                   enable,
   input  wire logic [4:0]             code,
   input  wire logic [3:0]             slot,
   output      led_bank_pkg::level_type level,
   output      logic                   sink_on
);
   logic [4:0] duty;
   level_type  next_level;

   // Analog step and duty in sixteenths from the brightness code.
   always_comb begin
      if (code < 5'h10) begin
         next_level = level_20;
         duty = 5'(code + 5'h01);
      end else if (code < 5'h17) begin
         next_level = level_40;
         duty = 5'(code - 5'h06);
      end else if (code < 5'h1D) begin
         next_level = level_70;
         duty = 5'(code - 5'h0C);
      end else begin
         next_level = level_100;
         duty = 5'(code - 5'h0F);
      end
   end

   // Registered outputs keep the sink drive free of decode glitches.
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         level <= level_20;
         sink_on <= 1'b0;
      end else begin
         level <= next_level;
         sink_on <= enable && ({1'b0, slot} < duty);
      end
   end
endmodule // brightness_pwm

//--- hw/led_bank_device.sv
/*
  Device end of the LED bank serial control: two-wire write-only slave, internal
  registers, PWM brightness for the main and aux groups, and pump gain choice.
  Assumes the link signals and the headroom comparator flags are asynchronous to clk_sys;
  all of them pass two flip-flops before use.
*/
`timescale 1ns/1ps
`include "led_bank_defs.svh"

// Functional notes
// - Main and aux groups: 32 steps, analog plus PWM.
// - Indicator: four analog steps, no PWM.
// - Pass mode; boost to 3/2 on low headroom.
// - Only enabled sink pins affect gain.
// - Pin5 and pin3 sensing disabled by bits.
// - Indicator sink never affects pump gain.
// - Reset pin low restores defaults, disables.
// - Host holds reset pin high normally.
// - Master changes data only while clock low.
// - Start and stop generated and detected.
// - Bus busy from start until stop.
// - Repeated start restarts address reception.
// - Master sends eight bits, MSB first, plus ack.
// - Master releases data during ack pulse.
// - Device pulls data low on ninth pulse.
// - First byte: seven-bit address, direction bit.
// - Address 36h standard, 38h alternate variant.
// - Second write byte selects internal register.
// - Third byte stored in selected register.
// - General register defaults 20h, five enables.
// - Brightness codes: 5-bit, 5-bit, 2-bit.
module led_bank_device
   import led_bank_pkg::*;
#(
   parameter bit ALT_VARIANT = 1'b0
)
(
   input  wire logic                    clk_sys,
   input  wire logic                    rst,
   led_bank_if.device                   bus,
   input  wire logic [4:0]              main_headroom_low,
   input  wire logic [2:0]              aux_headroom_low,
   output      logic                    main_group_enable,
   output      logic                    aux_group_enable,
   output      logic                    indicator_enable,
   output      logic                    main_pin5_sense_enable,
   output      logic                    aux_pin3_drive_sense_enable,
   output      logic                    main_sink_on,
   output      led_bank_pkg::level_type main_level,
   output      logic                    aux_sink_on,
   output      logic                    aux_pin3_sink_on,
   output      led_bank_pkg::level_type aux_level,
   output      logic                    indicator_sink_on,
   output      led_bank_pkg::level_type indicator_level,
   output      logic                    pump_gain_boost,
   output      logic                    bus_busy
);
   import led_bank_pkg::*;

   localparam logic [6:0] OWN_ADDR = ALT_VARIANT ? `LBC_ADDR_ALT : `LBC_ADDR_STD;
   localparam logic [9:0] SLOT_LAST = 10'(`LBC_PWM_SLOT_CYC - 1);

   logic            scl_meta;
   logic            scl_sync;
   logic            scl_prev;
   logic            sda_meta;
   logic            sda_sync;
   logic            sda_prev;
   logic            rstn_meta;
   logic            rstn_sync;
   logic [4:0]      main_low_meta;
   logic [4:0]      main_low_sync;
   logic [2:0]      aux_low_meta;
   logic [2:0]      aux_low_sync;
   logic            core_rst;
   logic            scl_rise;
   logic            scl_fall;
   logic            start_seen;
   logic            stop_seen;
   slave_state_type state;
   logic [3:0]      bit_count;
   logic [1:0]      byte_index;
   logic [7:0]      shift;
   logic [7:0]      reg_select;
   logic            sda_drive_low;
   logic            write_strobe;
   logic [7:0]      write_data;
   logic [4:0]      gp_enables;
   logic [4:0]      main_code;
   logic [4:0]      aux_code;
   logic [1:0]      ind_code;
   logic [4:0]      main_monitor;
   logic [2:0]      aux_monitor;
   logic [9:0]      slot_timer;
   logic [3:0]      slot;

   // Two-stage synchronisers for every pin; only the second stage is read onward.
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         scl_meta <= 1'b1;
         scl_sync <= 1'b1;
         sda_meta <= 1'b1;
         sda_sync <= 1'b1;
         rstn_meta <= 1'b0;
         rstn_sync <= 1'b0;
         main_low_meta <= 5'h00;
         main_low_sync <= 5'h00;
         aux_low_meta <= 3'h0;
         aux_low_sync <= 3'h0;
      end else begin
         scl_meta <= bus.scl;
         scl_sync <= scl_meta;
         sda_meta <= bus.sda;
         sda_sync <= sda_meta;
         rstn_meta <= bus.reset_n;
         rstn_sync <= rstn_meta;
         main_low_meta <= main_headroom_low;
         main_low_sync <= main_low_meta;
         aux_low_meta <= aux_headroom_low;
         aux_low_sync <= aux_low_meta;
      end
   end

   // Delayed copies for edge detection, taken from the second stage only.
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         scl_prev <= 1'b1;
         sda_prev <= 1'b1;
      end else begin
         scl_prev <= scl_sync;
         sda_prev <= sda_sync;
      end
   end

   // The reset pin acts like the system reset on all control state.
   assign core_rst = rst || !rstn_sync;

   // Line events; start and stop need the clock high in both samples.
   assign scl_rise = scl_sync && !scl_prev;
   assign scl_fall = !scl_sync && scl_prev;
   assign start_seen = scl_sync && scl_prev && sda_prev && !sda_sync;
   assign stop_seen = scl_sync && scl_prev && !sda_prev && sda_sync;

   // Busy from any start until a stop.
   always_ff @(posedge clk_sys) begin
      if (core_rst) begin
         bus_busy <= 1'b0;
      end else if (start_seen) begin
         bus_busy <= 1'b1;
      end else if (stop_seen) begin
         bus_busy <= 1'b0;
      end
   end

   // Slave state machine. Bits are taken on the rising clock edge, and the
   // acknowledge is driven from the falling edge after the eighth bit until the
   // falling edge after the ninth, so the line never moves while the clock is high.
   always_ff @(posedge clk_sys) begin
      if (core_rst) begin
         state <= slave_idle;
         bit_count <= 4'h0;
         byte_index <= 2'h0;
         shift <= 8'h00;
         reg_select <= 8'h00;
         sda_drive_low <= 1'b0;
         write_strobe <= 1'b0;
         write_data <= 8'h00;
      end else begin
         write_strobe <= 1'b0;
         if (start_seen) begin
            state <= slave_shift;
            bit_count <= 4'h0;
            byte_index <= 2'h0;
            sda_drive_low <= 1'b0;
         end else if (stop_seen) begin
            state <= slave_idle;
            sda_drive_low <= 1'b0;
         end else begin
            case (state)
               slave_shift: begin
                  if (scl_rise && bit_count < 4'h8) begin
                     shift <= {shift[6:0], sda_sync};
                     bit_count <= 4'(bit_count + 4'h1);
                  end else if (scl_fall && bit_count == 4'h8) begin
                     state <= slave_ack;
                     sda_drive_low <= 1'b1;
                     if (byte_index == 2'h0) begin
                        // Reads are not served: a read request is refused like a foreign address.
                        if (shift[7:1] != OWN_ADDR || shift[0]) begin
                           state <= slave_ignore;
                           sda_drive_low <= 1'b0;
                        end
                     end else if (byte_index == 2'h1) begin
                        reg_select <= shift;
                     end else begin
                        write_strobe <= 1'b1;
                        write_data <= shift;
                     end
                  end
               end
               slave_ack: begin
                  if (scl_fall) begin
                     sda_drive_low <= 1'b0;
                     state <= slave_shift;
                     bit_count <= 4'h0;
                     if (byte_index != 2'h2) begin
                        byte_index <= 2'(byte_index + 2'h1);
                     end
                  end
               end
               slave_ignore: begin
                  sda_drive_low <= 1'b0;
               end
               default: begin
                  sda_drive_low <= 1'b0;
               end
            endcase
         end
      end
   end

   // Open-drain data: drive low only while acknowledging.
   assign bus.dev_sda_out = 1'b0;
   assign bus.dev_sda_oe = sda_drive_low;

   // Internal registers; each later data byte rewrites the same selected register.
   always_ff @(posedge clk_sys) begin
      if (core_rst) begin
         gp_enables <= 5'(`LBC_RST_GP);
         main_code <= 5'(`LBC_RST_MAIN);
         aux_code <= 5'(`LBC_RST_AUX);
         ind_code <= 2'(`LBC_RST_IND);
      end else if (write_strobe) begin
         case (reg_select)
            `LBC_REG_GP: gp_enables <= write_data[4:0];
            `LBC_REG_MAIN: main_code <= write_data[4:0];
            `LBC_REG_AUX: aux_code <= write_data[4:0];
            `LBC_REG_IND: ind_code <= write_data[1:0];
            default: begin
            end
         endcase
      end
   end

   assign main_group_enable = gp_enables[`LBC_GP_MAIN_EN];
   assign aux_group_enable = gp_enables[`LBC_GP_AUX_EN];
   assign indicator_enable = gp_enables[`LBC_GP_IND_EN];
   assign main_pin5_sense_enable = gp_enables[`LBC_GP_PIN5_SENSE];
   assign aux_pin3_drive_sense_enable = gp_enables[`LBC_GP_PIN3_EN];

   // PWM time base: 16 slots make one period at the internal PWM rate.
   always_ff @(posedge clk_sys) begin
      if (core_rst) begin
         slot_timer <= 10'h000;
         slot <= 4'h0;
      end else if (slot_timer == SLOT_LAST) begin
         slot_timer <= 10'h000;
         slot <= 4'(slot + 4'h1);
      end else begin
         slot_timer <= 10'(slot_timer + 10'h001);
      end
   end

   brightness_pwm main_pwm (
      .clk_sys (clk_sys),
      .rst     (core_rst),
      .enable  (main_group_enable),
      .code    (main_code),
      .slot    (slot),
      .level   (main_level),
      .sink_on (main_sink_on)
   );

   brightness_pwm aux_pwm (
      .clk_sys (clk_sys),
      .rst     (core_rst),
      .enable  (aux_group_enable),
      .code    (aux_code),
      .slot    (slot),
      .level   (aux_level),
      .sink_on (aux_sink_on)
   );

   // Indicator and pin3 driver outputs, registered like the PWM outputs.
   always_ff @(posedge clk_sys) begin
      if (core_rst) begin
         indicator_sink_on <= 1'b0;
         indicator_level <= level_20;
         aux_pin3_sink_on <= 1'b0;
      end else begin
         indicator_sink_on <= indicator_enable;
         indicator_level <= level_type'(ind_code);
         aux_pin3_sink_on <= aux_sink_on && aux_pin3_drive_sense_enable;
      end
   end

   // Pins that take part in the gain decision; the indicator has no input here.
   assign main_monitor = {main_group_enable && main_pin5_sense_enable, {4{main_group_enable}}};
   assign aux_monitor = {aux_group_enable && aux_pin3_drive_sense_enable, {2{aux_group_enable}}};

   // Gain stays at 3/2 once chosen; it only drops back when nothing is monitored,
   // which avoids hunting between gains around the threshold.
   always_ff @(posedge clk_sys) begin
      if (core_rst) begin
         pump_gain_boost <= 1'b0;
      end else if (|(main_low_sync & main_monitor) || |(aux_low_sync & aux_monitor)) begin
         pump_gain_boost <= 1'b1;
      end else if (main_monitor == 5'h00 && aux_monitor == 3'h0) begin
         pump_gain_boost <= 1'b0;
      end
   end
endmodule // led_bank_device

//--- hw/led_bank_host.sv
/*
  Host end of the LED bank serial control: a write-only two-wire master that sends
  address, register selector and one data byte per command, and drives the reset pin.
  Assumes the device end is reached through led_bank_if; the clock is made here by division.
*/
`timescale 1ns/1ps
`include "led_bank_defs.svh"

module led_bank_host
   import led_bank_pkg::*;
#(
   parameter bit TARGET_ALT = 1'b0
)
(
   input  wire logic       clk_sys,
   input  wire logic       rst,
   led_bank_if.host        bus,
   input  wire logic       hold_device_reset,
   input  wire logic       cmd_valid,
   output      logic       cmd_ready,
   input  wire logic [7:0] cmd_register,
   input  wire logic [7:0] cmd_data,
   output      logic       done,
   output      logic       nack,
   output      logic       busy
);
   import led_bank_pkg::*;

   localparam logic [6:0] TARGET_ADDR = TARGET_ALT ? `LBC_ADDR_ALT : `LBC_ADDR_STD;
   localparam logic [7:0] QUARTER_LAST = 8'(`LBC_SCL_QUARTER_CYC - 1);

   host_state_type state;
   logic [7:0]     quarter_timer;
   logic           tick;
   logic [1:0]     phase;
   logic [3:0]     bit_idx;
   logic [1:0]     byte_idx;
   logic [7:0]     reg_hold;
   logic [7:0]     data_hold;
   logic [7:0]     cur_byte;
   logic           sda_low;
   logic           sda_meta;
   logic           sda_sync;
   logic           scl_level;
   logic           reset_pin;

   // Data line is sampled through two flip-flops before the ack check.
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         sda_meta <= 1'b1;
         sda_sync <= 1'b1;
      end else begin
         sda_meta <= bus.sda;
         sda_sync <= sda_meta;
      end
   end

   // Reset pin stays high unless the user asks to hold the device in reset.
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         reset_pin <= 1'b1;
      end else begin
         reset_pin <= !hold_device_reset;
      end
   end

   // Quarter-period divider runs only during a transfer.
   always_ff @(posedge clk_sys) begin
      if (rst || state == host_idle || tick) begin
         quarter_timer <= 8'h00;
      end else begin
         quarter_timer <= 8'(quarter_timer + 8'h01);
      end
   end
   assign tick = (quarter_timer == QUARTER_LAST);

   always_comb begin
      case (byte_idx)
         2'h0: cur_byte = {TARGET_ADDR, 1'b0};
         2'h1: cur_byte = reg_hold;
         default: cur_byte = data_hold;
      endcase
   end

   // Master sequencer: data moves one quarter after the clock falls, so it is
   // stable over the whole high time; the ack is read at the end of the high time.
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         state <= host_idle;
         phase <= 2'h0;
         bit_idx <= 4'h0;
         byte_idx <= 2'h0;
         reg_hold <= 8'h00;
         data_hold <= 8'h00;
         sda_low <= 1'b0;
         scl_level <= 1'b1;
         done <= 1'b0;
         nack <= 1'b0;
      end else begin
         done <= 1'b0;
         case (state)
            host_idle: begin
               if (cmd_valid) begin
                  reg_hold <= cmd_register;
                  data_hold <= cmd_data;
                  nack <= 1'b0;
                  byte_idx <= 2'h0;
                  bit_idx <= 4'h0;
                  phase <= 2'h0;
                  state <= host_start;
               end
            end
            host_start: begin
               if (tick) begin
                  phase <= 2'(phase + 2'h1);
                  if (phase == 2'h0) begin
                     sda_low <= 1'b1;
                  end else begin
                     scl_level <= 1'b0;
                     phase <= 2'h0;
                     state <= host_bit;
                  end
               end
            end
            host_bit: begin
               if (tick) begin
                  phase <= 2'(phase + 2'h1);
                  case (phase)
                     2'h0: sda_low <= (bit_idx == 4'h8) ? 1'b0 : !cur_byte[3'(4'h7 - bit_idx)];
                     2'h1: scl_level <= 1'b1;
                     2'h3: begin
                        scl_level <= 1'b0;
                        bit_idx <= 4'(bit_idx + 4'h1);
                        if (bit_idx == 4'h8) begin
                           bit_idx <= 4'h0;
                           byte_idx <= 2'(byte_idx + 2'h1);
                           if (sda_sync) begin
                              nack <= 1'b1;
                              state <= host_stop;
                           end else if (byte_idx == 2'h2) begin
                              state <= host_stop;
                           end
                        end
                     end
                     default: begin
                     end
                  endcase
               end
            end
            host_stop: begin
               if (tick) begin
                  phase <= 2'(phase + 2'h1);
                  case (phase)
                     2'h0: sda_low <= 1'b1;
                     2'h1: scl_level <= 1'b1;
                     2'h2: sda_low <= 1'b0;
                     default: begin
                        done <= 1'b1;
                        state <= host_idle;
                     end
                  endcase
               end
            end
            default: state <= host_idle;
         endcase
      end
   end

   assign cmd_ready = (state == host_idle);
   assign busy = (state != host_idle);
   assign bus.scl = scl_level;
   assign bus.reset_n = reset_pin;
   assign bus.host_sda_out = 1'b0;
   assign bus.host_sda_oe = sda_low;
endmodule // led_bank_host

//--- sim/led_bank_link_assertions.sv
/* Checker of the two-wire link between host and device end.
   Assumes the bench hands in the interface signals plus clk_sys and rst by name. */
`timescale 1ns/1ps
module led_bank_link_assertions (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic scl,
   input wire logic reset_n,
   input wire logic host_sda_oe,
   input wire logic dev_sda_oe
);
   // One clock domain, so clocking and reset are stated once.
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (rst);

   // Acknowledge must last over the next full high phase of the link clock.
   sequence ack_pulse;
      ##[1:80] $rose(scl) ##[1:40] $fell(scl);
   endsequence

   a_idle_after_reset: assert property ($fell(rst) |-> scl && !host_sda_oe && reset_n)
      else $error("link not idle after reset");
   a_dev_quiet_reset: assert property (!reset_n [*5] |-> !dev_sda_oe)
      else $error("device drives data in reset");
   a_ack_host_free: assert property (scl && dev_sda_oe |-> !host_sda_oe)
      else $error("host drives data in ack pulse");
   a_ack_starts_low: assert property ($rose(dev_sda_oe) |-> !scl)
      else $error("ack begins while clock high");
   a_ack_ends_low: assert property ($fell(dev_sda_oe) |-> !scl)
      else $error("ack ends while clock high");
   a_ack_spans_pulse: assert property ($rose(dev_sda_oe) |-> dev_sda_oe throughout ack_pulse)
      else $error("ack does not cover the ninth pulse");
   a_data_setup: assert property ($rose(scl) |-> $stable(host_sda_oe) && $stable(dev_sda_oe))
      else $error("data moves at clock rise");
   a_scl_high_len: assert property ($rose(scl) |-> scl [*8])
      else $error("clock high phase too short");
endmodule // led_bank_link_assertions

//--- sim/tb_led_bank_serial_control.sv
/* Self-checking bench: host and device ends joined by the link interface.
   Assumes the host makes the link clock; tests are host writes and port checks. */
`timescale 1ns/1ps
`include "led_bank_defs.svh"
module tb_led_bank_serial_control;
   import led_bank_pkg::*;
   logic      clk_sys, rst, hold_device_reset, cmd_valid, cmd_ready, done, nack, busy;
   logic      seen_busy = 1'b0;
   logic      main_group_enable, aux_group_enable, indicator_enable, main_pin5_sense_enable;
   logic      aux_pin3_drive_sense_enable, main_sink_on, aux_sink_on, aux_pin3_sink_on;
   logic      indicator_sink_on, pump_gain_boost, bus_busy;
   logic [7:0] cmd_register, cmd_data;
   logic [4:0] main_headroom_low;
   logic [2:0] aux_headroom_low;
   logic [8:0] wire_bits;
   level_type main_level, aux_level, indicator_level;
   int        failures = 0, comparisons = 0, on_count;
   wire [4:0] enables = {main_group_enable, aux_group_enable, indicator_enable, main_pin5_sense_enable,
                         aux_pin3_drive_sense_enable};
   led_bank_if bus ();
   led_bank_host u_led_bank_host (.*);
   led_bank_device u_led_bank_device (.*);
   led_bank_link_assertions u_led_bank_link_assertions (.clk_sys(clk_sys), .rst(rst), .scl(bus.scl),
      .reset_n(bus.reset_n), .host_sda_oe(bus.host_sda_oe), .dev_sda_oe(bus.dev_sda_oe));

   task check(input logic [15:0] got, input logic [15:0] exp);
      comparisons++;
      if (got !== exp) begin
         failures++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // One host command; the wait is bounded so a lost done cannot hang the run.
   task write(input logic [7:0] sel, input logic [7:0] val);
      int n;
      @(negedge clk_sys);
      cmd_register = sel;
      cmd_data = val;
      cmd_valid = 1'b1;
      @(negedge clk_sys);
      cmd_valid = 1'b0;
      for (n = 0; n < 3000 && done !== 1'b1; n++) @(negedge clk_sys);
      check(16'({done, nack}), 16'h0002);
      repeat (10) @(negedge clk_sys);
   endtask

   task summarize;
      $display("comparisons=%0d failures=%0d", comparisons, failures);
      if (failures == 0 && comparisons > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask

   // System clock at 20 MHz.
   initial begin
      clk_sys = 1'b0;
      forever #25 clk_sys = ~clk_sys;
   end

   // Hang guard, about twice the length of all tests.
   initial begin
      #1000000;
      failures++;
      summarize();
   end

   // Remember that the device saw the bus occupied.
   always @(posedge clk_sys) if (bus_busy === 1'b1) seen_busy <= 1'b1;

   // After every start, collect the address byte and its acknowledge from the wire.
   initial forever begin
      @(negedge bus.sda iff (bus.scl === 1'b1));
      repeat (9) begin
         @(posedge bus.scl);
         wire_bits = {wire_bits[7:0], bus.sda};
      end
      check(16'(wire_bits), 16'({`LBC_ADDR_STD, 1'b0, 1'b0}));
   end

   // Main sequence.
   initial begin
      rst = 1'b1;
      hold_device_reset = 1'b0;
      cmd_valid = 1'b0;
      cmd_register = 8'h00;
      cmd_data = 8'h00;
      main_headroom_low = 5'h00;
      aux_headroom_low = 3'h0;
      repeat (2) @(negedge clk_sys);
      rst = 1'b0;
      repeat (5) @(negedge clk_sys);
      check(16'(enables), 16'h0000);
      check(16'(indicator_level), 16'(level_20));
      $display("test defaults done");
      write(`LBC_REG_GP, 8'h01);
      check(16'({seen_busy, bus_busy}), 16'h0002);
      aux_headroom_low = 3'h7;
      main_headroom_low = 5'h10;
      repeat (8) @(negedge clk_sys);
      check(16'(pump_gain_boost), 16'h0000);
      main_headroom_low = 5'h01;
      repeat (4) @(negedge clk_sys);
      check(16'(pump_gain_boost), 16'h0001);
      main_headroom_low = 5'h00;
      aux_headroom_low = 3'h0;
      $display("test gain done");
      write(`LBC_REG_GP, 8'hFF);
      check(16'(enables), 16'h001F);
      write(`LBC_REG_MAIN, 8'hFF);
      check(16'(main_level), 16'(level_100));
      write(`LBC_REG_AUX, 8'h10);
      check(16'(aux_level), 16'(level_40));
      write(`LBC_REG_IND, 8'hFE);
      check(16'({indicator_sink_on, indicator_level}), 16'({1'b1, level_70}));
      // Over one whole PWM period the on-cycles count sixteenths: main 16, aux and pin3 10 each,
      // indicator 16 since it has no PWM. Any window of one period gives the same sum.
      on_count = 0;
      repeat (16 * `LBC_PWM_SLOT_CYC) @(negedge clk_sys)
         on_count += main_sink_on + aux_sink_on + aux_pin3_sink_on + indicator_sink_on;
      check(16'(on_count), 16'(52 * `LBC_PWM_SLOT_CYC));
      $display("test levels done");
      hold_device_reset = 1'b1;
      repeat (10) @(negedge clk_sys);
      check(16'({enables, pump_gain_boost, main_level}), 16'h0000);
      hold_device_reset = 1'b0;
      repeat (5) @(negedge clk_sys);
      $display("test reset pin done");
      summarize();
   end
endmodule // tb_led_bank_serial_control
